//--- src/cfrm_pkg.sv
package cfrm_pkg;

    // ****************************************************************
    // Board population
    // ****************************************************************
    localparam int NFPGA = 5;
    localparam int NPROC = 5;
    localparam int FL_AW = 21;

    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [31:0] RECFG_CMD_OFS   = 32'h0C00_0000;
    localparam logic [31:0] RESET_CMD_OFS   = 32'h0C00_0004;
    localparam logic [31:0] PROC_RESET_OFS  = 32'h00C0_0010;
    localparam logic [31:0] RECFG_STAT_OFS  = 32'h00C0_0020;
    localparam logic [31:0] RESET_STAT_OFS  = 32'h00C0_0024;
    localparam logic [31:0] FL_ADDAT_OFS    = 32'h00C0_0040;
    localparam logic [31:0] FL_CTRL_OFS     = 32'h00C0_0044;
    localparam logic [31:0] FL_RDATA_OFS    = 32'h00C0_0048;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int ALL_BIT      = 5;
    localparam int FL_RD_BIT    = 0;
    localparam int FL_AUTO_BIT  = 1;
    localparam int FL_MAN_BIT   = 2;
    localparam int FA_ADDR_LSB  = 0;
    localparam int FA_DATA_LSB  = 24;
    localparam logic [4:0] ALL_DONE      = 5'h1F;
    localparam logic [4:0] RECFG_PEND_RST = 5'h1F;
    localparam logic [4:0] STAT_RST      = 5'h00;

    // ****************************************************************
    // Flash unlock sequence for byte program
    // ****************************************************************
    localparam logic [FL_AW-1:0] UNL_ADDR_A = 21'h000555;
    localparam logic [FL_AW-1:0] UNL_ADDR_B = 21'h0002AA;
    localparam logic [7:0] UNL_DATA_A = 8'hAA;
    localparam logic [7:0] UNL_DATA_B = 8'h55;
    localparam logic [7:0] PROG_CMD   = 8'hA0;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_NS       = 40;
    localparam int RST_PULSE_NS = 100;
    localparam int CFG_BIT_NS   = 50;
    localparam int ERASE_NS     = 500;
    localparam int FL_RD_NS     = 90;
    localparam int FL_WE_NS     = 50;
    localparam logic [15:0] RST_CYC   = 16'((RST_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] BIT_CYC   = 16'((CFG_BIT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] ERASE_CYC = 16'((ERASE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] FL_RD_CYC = 16'((FL_RD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] FL_WE_CYC = 16'((FL_WE_NS + CLK_NS - 1) / CLK_NS);

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_ERASE, ST_CRD, ST_SHIFT, ST_FRD, ST_FWR, ST_FWAIT
    } cfrm_state_t;

    typedef struct packed {
        logic        strobe;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cfrm_host_req_t;

    typedef struct packed {
        logic [FL_AW-1:0] addr;
        logic [7:0]       dq_o;
        logic             dq_oe;
        logic             ce_n;
        logic             oe_n;
        logic             we_n;
    } cfrm_flash_t;

    localparam cfrm_flash_t FL_IDLE = '{addr: '0, dq_o: 8'h00, dq_oe: 1'b0,
                                       ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};

endpackage

//--- src/cfrm_manager.sv
`timescale 1ns/1ps

// Behaviour
// RULE1: Busy toward timing module stays high during any reset or configuration.
// RULE2: Power-up or panel switch configures every FPGA, then reboots master processor.
// RULE3: Host reaches registers by 32-bit address, 32-bit data, single or block.
// RULE4: Configuration erases the target FPGA, then shifts its serial bitstream in.
// RULE5: FPGA reset command gives one 100 ns reset pulse; the code holds it for 3 clock cycles of 40 ns, 120 ns.
// RULE6: FPGA reset leaves internal RAM contents alone; only logic state resets.
// RULE7: At power-up images load from flash into all FPGAs without host action.
// RULE8: Host should follow each reconfiguration with an FPGA reset.
// RULE9: Configuration and FPGA resets never touch processor memories.
// RULE10: Each FPGA and each processor has its own reset and configure control.
// RULE11: Host writes 0x20 to reconfigure command to reconfigure all FPGAs.
// RULE12: Reconfigure status reads 0x1F once all devices are configured.
// RULE13: Host writes 0x20 to reset command to reset all FPGAs.
// RULE14: Reset status reads 0x1F once all resets have finished.
// RULE15: Processor resets are accepted at any time, whatever the data path does.
// RULE16: Reset register offers a soft reset reaching every connected device.
// RULE17: Flash read: address, set read bit, data stored, read bit clears.
// RULE18: Manual write mode passes host-built flash command cycles straight through.
// RULE19: Automated write mode runs the whole byte-program cycle from one request.
// RULE20: Automated write bit self-clears when programming ends.
// RULE21: Host uses automated write only on erased sectors.
// RULE22: Two-wire link reports busy and carries slave processor reset requests.
module cfrm_manager #(
    parameter int          CFG_BYTES = 1024,
    parameter logic [15:0] PROG_WAIT = 16'd500
) (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    nrst,
    // Host register port
    input  cfrm_pkg::cfrm_host_req_t     host_req,
    output logic                         host_ack,
    output logic [31:0]                  host_rdata,
    // Configuration flash
    output cfrm_pkg::cfrm_flash_t        flash,
    input  wire logic [7:0]              flash_dq_i,
    // FPGA configuration, FPGA and processor resets
    output logic [cfrm_pkg::NFPGA-1:0]   cfg_prog_n,
    output logic                         cfg_cclk,
    output logic                         cfg_din,
    output logic [cfrm_pkg::NFPGA-1:0]   fpga_rst,
    output logic [cfrm_pkg::NPROC-1:0]   proc_rst,
    // Board status and controls
    input  wire logic                    panel_rst_n,
    output logic                         rod_busy,
    // Two-wire processor link
    input  wire logic                    link_rst_req,
    output logic                         link_busy
);
    import cfrm_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (CFG_BYTES < 2 || CFG_BYTES * NFPGA > (1 << FL_AW)) begin : g_chk_bytes
        $error("CFG_BYTES does not fit the flash");
    end
    if (PROG_WAIT == 16'd0) begin : g_chk_wait
        $error("PROG_WAIT must be at least one cycle");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [2:0] first_set(input logic [NFPGA-1:0] m);
        logic [2:0] r;
        r = 3'h0;
        for (int i = NFPGA - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    function automatic cfrm_flash_t wr_cycle(input logic [1:0] step, input logic [FL_AW-1:0] a,
                                             input logic [7:0] d);
        cfrm_flash_t f;
        f = '{addr: a, dq_o: d, dq_oe: 1'b1, ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
        case (step)
            2'd0: begin
                f.addr = UNL_ADDR_A;
                f.dq_o = UNL_DATA_A;
            end
            2'd1: begin
                f.addr = UNL_ADDR_B;
                f.dq_o = UNL_DATA_B;
            end
            2'd2: begin
                f.addr = UNL_ADDR_A;
                f.dq_o = PROG_CMD;
            end
            default: begin
            end
        endcase
        return f;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    cfrm_state_t      st_q,        st_d;
    logic [15:0]      cnt_q,       cnt_d;
    logic [FL_AW-1:0] byte_q,      byte_d;
    logic [2:0]       bit_q,       bit_d;
    logic [2:0]       cur_q,       cur_d;
    logic [1:0]       step_q,      step_d;
    logic [7:0]       sh_q,        sh_d;
    logic [NFPGA-1:0] recfg_pend_q, recfg_pend_d;
    logic [NFPGA-1:0] recfg_stat_q, recfg_stat_d;
    logic [NFPGA-1:0] reset_stat_q, reset_stat_d;
    logic [NFPGA-1:0] reset_pend_q, reset_pend_d;
    logic [31:0]      fl_addat_q,  fl_addat_d;
    logic [2:0]       fl_ctrl_q,   fl_ctrl_d;
    logic [7:0]       fl_rdata_q,  fl_rdata_d;
    logic [15:0]      rst_cnt_q,   rst_cnt_d;
    logic             boot_q,      boot_d;
    logic             panel_q,     panel_d;
    logic             link_q,      link_d;
    logic             ack_q,       ack_d;
    logic [31:0]      rdata_q,     rdata_d;
    cfrm_flash_t      fl_q,        fl_d;
    logic [NFPGA-1:0] prog_n_q,    prog_n_d;
    logic             cclk_q,      cclk_d;
    logic             din_q,       din_d;
    logic [NFPGA-1:0] fpga_rst_q,  fpga_rst_d;
    logic [NPROC-1:0] proc_rst_q,  proc_rst_d;
    logic             busy_q,      busy_d;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic [NFPGA-1:0] recfg_set;
        logic [NFPGA-1:0] freq;
        logic [NPROC-1:0] preq;
        logic             hw;
        recfg_set = '0;
        freq = '0;
        preq = '0;
        hw = host_req.strobe && host_req.write;
        st_d = st_q;
        cnt_d = cnt_q;
        byte_d = byte_q;
        bit_d = bit_q;
        cur_d = cur_q;
        step_d = step_q;
        sh_d = sh_q;
        recfg_pend_d = recfg_pend_q;
        recfg_stat_d = recfg_stat_q;
        reset_stat_d = reset_stat_q;
        reset_pend_d = reset_pend_q;
        fl_addat_d = fl_addat_q;
        fl_ctrl_d = fl_ctrl_q;
        fl_rdata_d = fl_rdata_q;
        rst_cnt_d = rst_cnt_q;
        boot_d = boot_q;
        panel_d = panel_rst_n;
        link_d = link_rst_req;
        fl_d = fl_q;
        prog_n_d = prog_n_q;
        cclk_d = cclk_q;
        din_d = din_q;
        fpga_rst_d = fpga_rst_q;
        proc_rst_d = proc_rst_q;
        ack_d = host_req.strobe;                                   // RULE3
        rdata_d = 32'h0000_0000;

        // Host commands and status clears; one word per strobe serves block mode
        if (hw) begin
            case (host_req.addr)
                RECFG_CMD_OFS: begin
                    recfg_set = host_req.wdata[ALL_BIT] ? ALL_DONE : host_req.wdata[NFPGA-1:0]; // RULE11
                    recfg_stat_d = recfg_stat_q & ~recfg_set;
                end
                RESET_CMD_OFS: begin
                    freq = host_req.wdata[ALL_BIT] ? ALL_DONE : host_req.wdata[NFPGA-1:0]; // RULE13
                    reset_stat_d = reset_stat_q & ~freq;
                end
                PROC_RESET_OFS: begin
                    preq = host_req.wdata[NPROC-1:0];              // RULE15 RULE10
                    if (host_req.wdata[ALL_BIT]) begin
                        preq = '1;                                 // RULE16
                        freq = '1;
                    end
                end
                FL_ADDAT_OFS: fl_addat_d = host_req.wdata;
                FL_CTRL_OFS: fl_ctrl_d = host_req.wdata[2:0];
                default: begin
                end
            endcase
        end else if (host_req.strobe) begin
            case (host_req.addr)
                RECFG_CMD_OFS:  rdata_d = {27'h0, recfg_pend_q};
                RESET_CMD_OFS:  rdata_d = {27'h0, reset_pend_q};
                PROC_RESET_OFS: rdata_d = {27'h0, proc_rst_q};
                RECFG_STAT_OFS: rdata_d = {27'h0, recfg_stat_q};   // RULE12
                RESET_STAT_OFS: rdata_d = {27'h0, reset_stat_q};   // RULE14
                FL_ADDAT_OFS:   rdata_d = fl_addat_q;
                FL_CTRL_OFS:    rdata_d = {29'h0, fl_ctrl_q};
                FL_RDATA_OFS:   rdata_d = {24'h0, fl_rdata_q};
                default:        rdata_d = 32'h0000_0000;
            endcase
        end

        // Panel switch press restarts the full power-up sequence
        if (panel_q && !panel_rst_n) begin
            recfg_set = ALL_DONE;                                  // RULE2
            recfg_stat_d = STAT_RST;
            boot_d = 1'b1;
        end
        // Slave processor reset request on the link
        if (link_rst_req && !link_q) begin
            preq[NPROC-1:1] = '1;                                  // RULE22
        end

        // Reset pulse generator; no RAM or flash path is touched by it
        if (boot_q && recfg_pend_q == '0 && st_q == ST_IDLE) begin
            preq[0] = 1'b1;                                        // RULE2
            boot_d = 1'b0;
        end
        if (freq != '0 || preq != '0) begin
            fpga_rst_d = fpga_rst_q | freq;                        // RULE5 RULE6
            proc_rst_d = proc_rst_q | preq;
            reset_pend_d = reset_pend_q | freq;
            rst_cnt_d = RST_CYC;
        end else if (rst_cnt_q != 16'd0) begin
            rst_cnt_d = rst_cnt_q - 16'd1;
            if (rst_cnt_q == 16'd1) begin
                fpga_rst_d = '0;
                proc_rst_d = '0;
                reset_stat_d = reset_stat_d | reset_pend_q;        // RULE14
                reset_pend_d = '0;
            end
        end

        // Configuration and flash engine; never drives processor resets
        case (st_q)
            ST_IDLE: begin
                if (recfg_pend_q != '0) begin
                    cur_d = first_set(recfg_pend_q);
                    prog_n_d[cur_d] = 1'b0;                        // RULE4 RULE9
                    cnt_d = ERASE_CYC - 16'd1;
                    byte_d = '0;
                    st_d = ST_ERASE;
                end else if (fl_ctrl_q[FL_RD_BIT]) begin
                    fl_d = FL_IDLE;                                // RULE17
                    fl_d.addr = fl_addat_q[FA_ADDR_LSB +: FL_AW];
                    fl_d.ce_n = 1'b0;
                    fl_d.oe_n = 1'b0;
                    cnt_d = FL_RD_CYC;
                    st_d = ST_FRD;
                end else if (fl_ctrl_q[FL_AUTO_BIT] || fl_ctrl_q[FL_MAN_BIT]) begin
                    step_d = fl_ctrl_q[FL_AUTO_BIT] ? 2'd0 : 2'd3;  // RULE18 RULE19
                    fl_d = wr_cycle(step_d, fl_addat_q[FA_ADDR_LSB +: FL_AW],
                                    fl_addat_q[FA_DATA_LSB +: 8]);
                    cnt_d = FL_WE_CYC;
                    st_d = ST_FWR;
                end
            end
            ST_ERASE: begin
                cnt_d = cnt_q - 16'd1;
                if (cnt_q == 16'd0) begin
                    prog_n_d = '1;
                    st_d = ST_CRD;
                    cnt_d = FL_RD_CYC;
                    fl_d = FL_IDLE;                                // RULE7
                    fl_d.addr = FL_AW'(int'(cur_q) * CFG_BYTES) + byte_q;
                    fl_d.ce_n = 1'b0;
                    fl_d.oe_n = 1'b0;
                end
            end
            ST_CRD: begin
                cnt_d = cnt_q - 16'd1;
                if (cnt_q == 16'd0) begin
                    sh_d = flash_dq_i;
                    fl_d = FL_IDLE;
                    bit_d = 3'd0;
                    cnt_d = BIT_CYC - 16'd1;
                    din_d = flash_dq_i[7];
                    cclk_d = 1'b0;
                    st_d = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                // Clock high on the last cycle of each bit cell
                cnt_d = cnt_q - 16'd1;
                cclk_d = (cnt_q == 16'd1) || (BIT_CYC == 16'd1);   // RULE4
                if (cnt_q == 16'd0) begin
                    cclk_d = 1'b0;
                    cnt_d = BIT_CYC - 16'd1;
                    bit_d = bit_q + 3'd1;
                    sh_d = {sh_q[6:0], 1'b0};
                    din_d = sh_q[6];
                    if (bit_q == 3'd7) begin
                        byte_d = byte_q + 1'b1;
                        if (byte_q == FL_AW'(CFG_BYTES - 1)) begin
                            recfg_pend_d[cur_q] = 1'b0;
                            recfg_stat_d[cur_q] = 1'b1;            // RULE12
                            st_d = ST_IDLE;
                        end else begin
                            st_d = ST_CRD;
                            cnt_d = FL_RD_CYC;
                            fl_d.addr = FL_AW'(int'(cur_q) * CFG_BYTES) + byte_d;
                            fl_d.ce_n = 1'b0;
                            fl_d.oe_n = 1'b0;
                        end
                    end
                end
            end
            ST_FRD: begin
                cnt_d = cnt_q - 16'd1;
                if (cnt_q == 16'd0) begin
                    fl_rdata_d = flash_dq_i;                       // RULE17
                    fl_ctrl_d[FL_RD_BIT] = 1'b0;
                    fl_d = FL_IDLE;
                    st_d = ST_IDLE;
                end
            end
            ST_FWR: begin
                // Write strobe rises one cycle before the next bus cycle
                cnt_d = cnt_q - 16'd1;
                if (cnt_q == 16'd1) begin
                    fl_d.we_n = 1'b1;
                end
                if (cnt_q == 16'd0) begin
                    fl_d = FL_IDLE;
                    if (step_q != 2'd3) begin
                        step_d = step_q + 2'd1;
                        fl_d = wr_cycle(step_d, fl_addat_q[FA_ADDR_LSB +: FL_AW],
                                        fl_addat_q[FA_DATA_LSB +: 8]);
                        cnt_d = FL_WE_CYC;
                    end else if (fl_ctrl_q[FL_AUTO_BIT]) begin
                        cnt_d = PROG_WAIT - 16'd1;
                        st_d = ST_FWAIT;
                    end else begin
                        fl_ctrl_d[FL_MAN_BIT] = 1'b0;              // RULE18
                        st_d = ST_IDLE;
                    end
                end
            end
            ST_FWAIT: begin
                // Fixed wait; the flash is not polled, so erased sectors only
                cnt_d = cnt_q - 16'd1;
                if (cnt_q == 16'd0) begin
                    fl_ctrl_d[FL_AUTO_BIT] = 1'b0;                 // RULE20
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase

        // New host requests win over the engine clearing them
        recfg_pend_d = recfg_pend_d | recfg_set;
        if (hw && host_req.addr == FL_CTRL_OFS) begin
            fl_ctrl_d = fl_ctrl_d | host_req.wdata[2:0];
        end
        busy_d = recfg_pend_d != '0 || prog_n_d != '1 || st_q == ST_ERASE || st_q == ST_CRD
                 || st_q == ST_SHIFT || fpga_rst_d != '0 || proc_rst_d != '0 || boot_d; // RULE1
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            byte_q <= '0;
            bit_q <= 3'h0;
            cur_q <= 3'h0;
            step_q <= 2'h0;
            sh_q <= 8'h00;
            recfg_pend_q <= RECFG_PEND_RST;                        // RULE7
            recfg_stat_q <= STAT_RST;
            reset_stat_q <= STAT_RST;
            reset_pend_q <= '0;
            fl_addat_q <= 32'h0000_0000;
            fl_ctrl_q <= 3'h0;
            fl_rdata_q <= 8'h00;
            rst_cnt_q <= 16'h0000;
            boot_q <= 1'b1;                                        // RULE2
            panel_q <= 1'b1;
            link_q <= 1'b0;
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            fl_q <= FL_IDLE;
            prog_n_q <= '1;
            cclk_q <= 1'b0;
            din_q <= 1'b0;
            fpga_rst_q <= '0;
            proc_rst_q <= '0;
            busy_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            byte_q <= byte_d;
            bit_q <= bit_d;
            cur_q <= cur_d;
            step_q <= step_d;
            sh_q <= sh_d;
            recfg_pend_q <= recfg_pend_d;
            recfg_stat_q <= recfg_stat_d;
            reset_stat_q <= reset_stat_d;
            reset_pend_q <= reset_pend_d;
            fl_addat_q <= fl_addat_d;
            fl_ctrl_q <= fl_ctrl_d;
            fl_rdata_q <= fl_rdata_d;
            rst_cnt_q <= rst_cnt_d;
            boot_q <= boot_d;
            panel_q <= panel_d;
            link_q <= link_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            fl_q <= fl_d;
            prog_n_q <= prog_n_d;
            cclk_q <= cclk_d;
            din_q <= din_d;
            fpga_rst_q <= fpga_rst_d;
            proc_rst_q <= proc_rst_d;
            busy_q <= busy_d;
        end
    end

    assign host_ack = ack_q;
    assign host_rdata = rdata_q;
    assign flash = fl_q;
    assign cfg_prog_n = prog_n_q;
    assign cfg_cclk = cclk_q;
    assign cfg_din = din_q;
    assign fpga_rst = fpga_rst_q;
    assign proc_rst = proc_rst_q;
    assign rod_busy = busy_q;
    assign link_busy = busy_q;                                     // RULE22

endmodule

//--- verification/cfrm_flash_mdl.sv
`timescale 1ns/1ps
module cfrm_flash_mdl (
    // Flash pins
    input wire logic              ref_clk,
    input cfrm_pkg::cfrm_flash_t  flash,
    output logic [7:0]            dq
);
    logic [7:0] mem [256];
    logic       armed;
    logic       we_q;
    initial begin
        armed = 1'h0;
        we_q = 1'h1;
        dq = 8'h00;
        for (int i = 0; i < 256; i++) mem[i] = ~8'(i);
    end
    always @(posedge ref_clk) begin
        we_q <= flash.we_n;
        if (!flash.ce_n && !flash.oe_n) dq <= mem[flash.addr[7:0]];
        else dq <= ~dq; // Released bus inverts each cycle, so no stale byte is held steady
        if (!flash.we_n && we_q && flash.dq_oe) begin
            if (armed) mem[flash.addr[7:0]] <= mem[flash.addr[7:0]] & flash.dq_o;
            armed <= (flash.dq_o == 8'hA0);
        end
    end
endmodule

//--- verification/cfrm_manager_chk.sv
`timescale 1ns/1ps
module cfrm_manager_chk (
    // Clock and reset
    input wire logic                 ref_clk,
    input wire logic                 nrst,
    // Watched ports
    input cfrm_pkg::cfrm_host_req_t  host_req,
    input wire logic                 host_ack,
    input cfrm_pkg::cfrm_flash_t     flash,
    input wire logic [4:0]           cfg_prog_n,
    input wire logic [4:0]           fpga_rst,
    input wire logic [4:0]           proc_rst,
    input wire logic                 rod_busy,
    input wire logic                 link_busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_ack; host_req.strobe |=> host_ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_src; host_ack |-> $past(host_req.strobe); endproperty
    a_src: assert property (p_src) else $error("stray ack");
    property p_bcfg; !(&cfg_prog_n) |-> rod_busy; endproperty
    a_bcfg: assert property (p_bcfg) else $error("idle while erasing");
    property p_brst; |fpga_rst |-> rod_busy; endproperty
    a_brst: assert property (p_brst) else $error("idle while resetting");
    property p_link; link_busy == rod_busy; endproperty
    a_link: assert property (p_link) else $error("link busy differs");
    property p_fpul; $rose(fpga_rst[0]) |-> fpga_rst[0] [*3] ##1 !fpga_rst[0]; endproperty
    a_fpul: assert property (p_fpul) else $error("fpga pulse length");
    property p_ppul; $rose(proc_rst[0]) |-> proc_rst[0] [*3] ##1 !proc_rst[0]; endproperty
    a_ppul: assert property (p_ppul) else $error("proc pulse length");
    property p_ers; $fell(cfg_prog_n[0]) |-> ##12 !cfg_prog_n[0] ##1 cfg_prog_n[0]; endproperty
    a_ers: assert property (p_ers) else $error("erase length");
    property p_we; !flash.we_n |-> flash.dq_oe && !flash.ce_n; endproperty
    a_we: assert property (p_we) else $error("write without drive");
    c_rst: cover property ($rose(fpga_rst[4]));
    c_proc: cover property ($rose(proc_rst[1]));
    c_we: cover property ($fell(flash.we_n));
endmodule
bind cfrm_manager cfrm_manager_chk chk_u (.*);

//--- verification/cfrm_manager_tb.sv
`timescale 1ns/1ps
module cfrm_manager_tb;
    import cfrm_pkg::*;
    logic           ref_clk = 1'h0;
    logic           nrst = 1'h0;
    logic           link_rst_req = 1'h0;
    cfrm_host_req_t host_req = '0;
    logic           host_ack, rod_busy, link_busy, cfg_cclk, cfg_din;
    logic [31:0]    host_rdata, rd;
    logic [7:0]     dq;
    cfrm_flash_t    flash;
    logic [4:0]     cfg_prog_n, fpga_rst, proc_rst;
    int             error_cnt = 0, total_checks = 0, cyc = 0;
    always #20 ref_clk = ~ref_clk;
    cfrm_manager #(.CFG_BYTES(4), .PROG_WAIT(16'h0004)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
        .host_req(host_req), .host_ack(host_ack), .host_rdata(host_rdata), .flash(flash), .flash_dq_i(dq),
        .cfg_prog_n(cfg_prog_n), .cfg_cclk(cfg_cclk), .cfg_din(cfg_din), .fpga_rst(fpga_rst),
        .proc_rst(proc_rst), .panel_rst_n(1'h1), .rod_busy(rod_busy), .link_rst_req(link_rst_req),
        .link_busy(link_busy));
    cfrm_flash_mdl mdl_u (.ref_clk(ref_clk), .flash(flash), .dq(dq));
    task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
        @(posedge ref_clk);
        host_req <= '{1'h1, w, a, d};
        @(posedge ref_clk);
        host_req.strobe <= 1'h0;
        #1 rd = host_rdata;
        chk("ack", 32'(host_ack), 32'h1);
    endtask
    task automatic poll(string n, logic [31:0] a, logic [31:0] m, logic [31:0] e);
        int i;
        i = 0;
        do begin
            bus(1'h0, a, 32'h0);
            i++;
        end while ((rd & m) !== e && i < 3000);
        chk(n, rd & m, e);
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic t_power();
        chk("busy", 32'(rod_busy), 32'h1);
        poll("cfg", RECFG_STAT_OFS, 32'hFF, 32'h1F);
        repeat (12) @(posedge ref_clk);
        chk("idle", 32'(rod_busy), 32'h0);
    endtask
    task automatic t_recfg();
        bus(1'h1, RECFG_CMD_OFS, 32'h20);
        chk("busy", 32'(rod_busy), 32'h1);
        poll("recfg", RECFG_STAT_OFS, 32'hFF, 32'h1F);
    endtask
    task automatic t_reset();
        bus(1'h1, RESET_CMD_OFS, 32'h04);
        chk("one", 32'(fpga_rst), 32'h04);
        bus(1'h1, RESET_CMD_OFS, 32'h20);
        chk("all", 32'(fpga_rst), 32'h1F);
        poll("rst", RESET_STAT_OFS, 32'hFF, 32'h1F);
    endtask
    task automatic t_proc();
        bus(1'h1, PROC_RESET_OFS, 32'h02);
        chk("proc", 32'(proc_rst), 32'h02);
        bus(1'h1, PROC_RESET_OFS, 32'h20);
        chk("soft", {fpga_rst, proc_rst}, 32'h3FF);
        repeat (6) @(posedge ref_clk);
        link_rst_req <= 1'h1;
        repeat (2) @(negedge ref_clk);
        chk("link", 32'(proc_rst), 32'h1E);
        @(posedge ref_clk);
        link_rst_req <= 1'h0;
    endtask
    task automatic t_flash();
        bus(1'h1, FL_ADDAT_OFS, 32'h3C00_0000);
        bus(1'h1, FL_CTRL_OFS, 32'h2);
        poll("wr", FL_CTRL_OFS, 32'h2, 32'h0);
        bus(1'h1, FL_CTRL_OFS, 32'h1);
        poll("rd", FL_CTRL_OFS, 32'h1, 32'h0);
        bus(1'h0, FL_RDATA_OFS, 32'h0);
        chk("byte", rd, 32'h3C);
        bus(1'h1, FL_CTRL_OFS, 32'h4);
        poll("man", FL_CTRL_OFS, 32'h4, 32'h0);
        bus(1'h0, 32'h00C0_0FF0, 32'h0);
        chk("unmapped", rd, 32'h0);
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1'h1;
        @(negedge ref_clk);
        t_power();
        t_recfg();
        t_reset();
        t_proc();
        t_flash();
        print_verdict();
    end
endmodule
